// ==== rtl/spm_pkg.sv ====
// Function
// R01: Each shared pin selectable system or port.
// R02: Reset brings every pin to default function.
// R03: Board holds erase pin low until remapped.
// R04: Debug pins start in debug port mode.
// R05: Pad settings apply in either pin mode; open drain and change detect here act in port mode only.
// R06: High scan select enters boundary-scan operation.
// R07: JTAG port active out of reset.
// R08: Host switch sequence enables serial-wire debug.
// R09: Trace output only while serial-wire active.
// R10: Reset pin bidirectional, drive or receive low.
// R11: Pin reset spares the backup domain.
// R12: Any pulse accepted, output reset stretched.
// R13: Reset pin defaults to input direction.
// R14: Qualified erase returns contents to all ones.
// R15: Erase input debounced on the slow clock.
// R16: Erase highs shorter than 100 ms ignored.
// R17: Erase needs high above 220 ms; the code erases after a 160 ms high.
// R18: Erase pin as output never erases.
// R19: Test input selects test or programming mode.
// R20: One fixed erase threshold inside the window.
// R21: Port lines have independent per-line pad options.
package spm_pkg;
   // ****************************************************
   // Pin selection bit positions
   // ****************************************************
   localparam int unsigned SYSIO_W = 13;       // Width of the selection word.
   localparam int unsigned BIT_TDI = 4;        // Debug data in.
   localparam int unsigned BIT_TDO = 5;        // Debug data out / trace.
   localparam int unsigned BIT_TMS = 6;        // Debug mode select / data.
   localparam int unsigned BIT_TCK = 7;        // Debug clock.
   localparam int unsigned BIT_DM = 10;        // USB data minus.
   localparam int unsigned BIT_DP = 11;        // USB data plus.
   localparam int unsigned BIT_ERASE = 12;     // Erase input.
   // Mask of implemented bits; a 1 in the selection word means port mode.
   localparam logic [12:0] SYSIO_MASK = 13'h1_CF0;
   localparam logic [12:0] SYSIO_RST = 13'h0_000; // All system functions.
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int unsigned SCLK_HZ = 32768;    // Slow clock rate.
   localparam int unsigned IGNORE_MS = 100;    // Highs shorter than this are ignored.
   localparam int unsigned ACCEPT_MS = 220;    // High that surely erases.
   // Threshold at 160 ms, between the two limits, in slow-clock ticks.
   localparam int unsigned ERASE_TICKS = SCLK_HZ * ((IGNORE_MS + ACCEPT_MS) / 2) / 1000;
   localparam int unsigned MCLK_MHZ = 125;     // Master clock rate.
   localparam int unsigned RST_MIN_US = 1;     // Least reset pulse driven out.
   localparam int unsigned RST_CYC = RST_MIN_US * MCLK_MHZ; // Stretch length.
   localparam int unsigned SJ_W = 4;           // Switch-detect state width.
endpackage

// ==== rtl/spm_erase_filter.sv ====
`timescale 1ns/1ns
module spm_erase_filter #(
   parameter int unsigned TICKS = spm_pkg::ERASE_TICKS // Slow-clock ticks needed.
) (
   input wire logic mclk,      // Master clock.
   input wire logic rst_n,     // Asynchronous reset, active low.
   input wire logic tick,      // One-cycle slow clock tick.
   input wire logic level,     // Qualified erase level.
   output logic fire           // One-cycle pulse when the level held long enough.
);
   import spm_pkg::*;
   // ****************************************************
   // Debounce counter
   // ****************************************************
   logic [23:0] cnt_reg; // Ticks seen high in a row.
   logic done_reg;       // Blocks a second fire within one press.
   // Highs count only on slow ticks, but a low on any master clock cycle restarts the count.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 24'h00_0000;
         done_reg <= 1'b0;
         fire <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (!level) begin
            // Any low sample restarts the count, so short highs never add up.
            cnt_reg <= 24'h00_0000; // see R16
            done_reg <= 1'b0;
         end else if (tick && !done_reg) begin
            if (cnt_reg == 24'(TICKS - 1)) begin
               fire <= 1'b1; // see R20
               done_reg <= 1'b1;
            end
            cnt_reg <= cnt_reg + 24'h00_0001; // see R15
         end
      end
   end
   a_fire_needs_count: assert property (@(posedge mclk) disable iff (!rst_n)
      fire |-> $past(cnt_reg) == 24'(TICKS - 1) && $past(level)) // see R16
      else $error("Erase fired before the threshold.");
endmodule

// ==== rtl/spm_sysio_ctrl.sv ====
`timescale 1ns/1ns
module spm_sysio_ctrl #(
   parameter int unsigned ERASE_TICKS = spm_pkg::ERASE_TICKS // Erase threshold in ticks.
) (
   input wire logic mclk,                        // Master clock, 125 MHz.
   input wire logic rst_n,                       // Asynchronous reset, active low.
   input wire logic sclk_tick,                   // One-cycle pulse per slow clock.
   input wire logic [spm_pkg::SYSIO_W-1:0] sel_wr, // New selection word.
   input wire logic sel_we,                      // Write strobe for the selection.
   input wire logic [spm_pkg::SYSIO_W-1:0] pad_pu, // Per-line pull-up setting.
   input wire logic [spm_pkg::SYSIO_W-1:0] pad_pd, // Per-line pull-down setting.
   input wire logic [spm_pkg::SYSIO_W-1:0] pad_od, // Per-line open-drain setting.
   input wire logic [spm_pkg::SYSIO_W-1:0] pad_gf, // Per-line glitch filter setting.
   input wire logic [spm_pkg::SYSIO_W-1:0] pad_db, // Per-line debounce setting.
   input wire logic [spm_pkg::SYSIO_W-1:0] pad_ic, // Per-line change-detect enable.
   input wire logic [spm_pkg::SYSIO_W-1:0] pin_in, // Pad input levels.
   input wire logic [spm_pkg::SYSIO_W-1:0] port_out, // Port output values.
   input wire logic [spm_pkg::SYSIO_W-1:0] port_oe, // Port output enables.
   input wire logic dbg_tdo, // Debug data out from jtag_debug_port.
   input wire logic dbg_tdo_oe, // Data out enable.
   input wire logic dbg_swdio_out, // Data from serial_wire_debug_port.
   input wire logic dbg_swdio_oe, // Enable for the serial data line.
   input wire logic trace_data, // Async trace stream.
   input wire logic usb_dm_out, // USB minus drive value.
   input wire logic usb_dp_out, // USB plus drive value.
   input wire logic usb_oe, // USB driver enable.
   input wire logic boundary_scan_select, // High selects boundary scan.
   input wire logic test_mode_input, // High selects test/programming mode.
   input wire logic reset_pin_n_in, // Level on the reset pin.
   input wire logic rstc_req, // Internal reset request pulse.
   output logic [spm_pkg::SYSIO_W-1:0] sel_q, // Current selection word.
   output logic [spm_pkg::SYSIO_W-1:0] pin_out, // Pad output values.
   output logic [spm_pkg::SYSIO_W-1:0] pin_oe, // Pad output enables.
   output logic [spm_pkg::SYSIO_W-1:0] pu_en, // Pad pull-up enables.
   output logic [spm_pkg::SYSIO_W-1:0] pd_en, // Pad pull-down enables.
   output logic [spm_pkg::SYSIO_W-1:0] gf_en, // Pad glitch filter enables.
   output logic [spm_pkg::SYSIO_W-1:0] db_en, // Pad debounce enables.
   output logic [spm_pkg::SYSIO_W-1:0] port_in, // Input levels to the port.
   output logic [spm_pkg::SYSIO_W-1:0] port_chg, // Change flags to the port.
   output logic dbg_tck, // Debug clock to the ports.
   output logic dbg_tms, // Mode/data in to the ports.
   output logic dbg_tdi, // Data in to jtag_debug_port.
   output logic swd_active, // Serial-wire port active.
   output logic scan_mode, // Boundary-scan operation.
   output logic test_mode, // Test or fast programming mode.
   output logic core_rst_n, // Core and peripheral reset, low active.
   output logic reset_pin_n_out, // Reset pin drive value.
   output logic reset_pin_n_oe, // Reset pin drive enable.
   output logic erase_req // One-cycle erase to all-ones request.
);
   import spm_pkg::*;
   // ****************************************************
   // Selection register
   // ****************************************************
   logic [SYSIO_W-1:0] sel_reg; // 1 = port line, 0 = system function.
   // Only implemented bits may move; the rest stay in system mode.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg <= SYSIO_RST; // see R02
      end else if (sel_we) begin
         sel_reg <= sel_wr & SYSIO_MASK; // see R01
      end
   end
   // ****************************************************
   // Debug port switch detect
   // ****************************************************
   // The host sends a long high run on the mode line then a fixed pattern.
   // Here it is reduced to 50 highs then the 16-bit code, LSB first.
   localparam logic [15:0] SWITCH_CODE = 16'hE7_9E;
   logic [5:0] high_cnt_reg; // Consecutive high mode bits.
   logic [4:0] code_cnt_reg; // Code bits matched.
   logic tck_q; // Previous clock sample for edge detection.
   logic swd_reg; // Serial-wire active flag.
   logic tck_rise; // Debug clock rising edge.
   assign tck_rise = dbg_tck && !tck_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tck_q <= 1'b0;
         high_cnt_reg <= 6'h00;
         code_cnt_reg <= 5'h00;
         swd_reg <= 1'b0; // see R07
      end else begin
         tck_q <= dbg_tck;
         if (tck_rise) begin
            if (dbg_tms) begin
               high_cnt_reg <= (high_cnt_reg == 6'h3F) ? high_cnt_reg : high_cnt_reg + 6'h01;
            end else begin
               high_cnt_reg <= 6'h00;
            end
            if (high_cnt_reg >= 6'h32 && code_cnt_reg == 5'h00) begin
               code_cnt_reg <= (dbg_tms == SWITCH_CODE[0]) ? 5'h01 : 5'h00;
            end else if (code_cnt_reg != 5'h00) begin
               if (dbg_tms == SWITCH_CODE[code_cnt_reg[3:0]]) begin
                  code_cnt_reg <= code_cnt_reg + 5'h01;
               end else begin
                  code_cnt_reg <= 5'h00;
               end
            end
         end
         if (code_cnt_reg == 5'h10) begin
            swd_reg <= 1'b1; // see R08
            code_cnt_reg <= 5'h00;
         end
      end
   end
   // ****************************************************
   // Pin multiplexer
   // ****************************************************
   logic [SYSIO_W-1:0] sys_out; // System-function drive values.
   logic [SYSIO_W-1:0] sys_oe; // System-function drive enables.
   always_comb begin
      sys_out = '0;
      sys_oe = '0;
      // Trace shares data-out and is offered only with serial-wire debug.
      sys_out[BIT_TDO] = swd_reg ? trace_data : dbg_tdo; // see R09
      sys_oe[BIT_TDO] = swd_reg ? 1'b1 : dbg_tdo_oe;
      sys_out[BIT_TMS] = dbg_swdio_out;
      sys_oe[BIT_TMS] = swd_reg & dbg_swdio_oe;
      sys_out[BIT_DM] = usb_dm_out;
      sys_out[BIT_DP] = usb_dp_out;
      sys_oe[BIT_DM] = usb_oe;
      sys_oe[BIT_DP] = usb_oe;
   end
   logic [SYSIO_W-1:0] pin_prev; // Previous pad levels for change flags.
   // Every pad output is registered; pull, glitch filter and debounce options pass in either mode.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
         pu_en <= '0;
         pd_en <= '0;
         gf_en <= '0;
         db_en <= '0;
         port_in <= '0;
         port_chg <= '0;
         pin_prev <= '0;
         sel_q <= SYSIO_RST;
      end else begin
         sel_q <= sel_reg;
         for (int i = 0; i < SYSIO_W; i++) begin
            if (sel_reg[i]) begin
               // Open drain drives only lows.
               pin_out[i] <= port_out[i]; // see R01
               pin_oe[i] <= port_oe[i] & (!pad_od[i] | !port_out[i]); // see R21
            end else begin
               pin_out[i] <= sys_out[i]; // see R04
               pin_oe[i] <= sys_oe[i];
            end
         end
         pu_en <= pad_pu; // see R05
         pd_en <= pad_pd; // see R05
         gf_en <= pad_gf; // see R21
         db_en <= pad_db; // see R21
         pin_prev <= pin_in;
         port_in <= pin_in & sel_reg;
         port_chg <= (pin_in ^ pin_prev) & pad_ic & sel_reg; // see R21
      end
   end
   // Debug inputs read the pad only while its line is in system mode.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dbg_tck <= 1'b0;
         dbg_tms <= 1'b1;
         dbg_tdi <= 1'b1;
         swd_active <= 1'b0;
         scan_mode <= 1'b0;
         test_mode <= 1'b0;
      end else begin
         dbg_tck <= !sel_reg[BIT_TCK] & pin_in[BIT_TCK]; // see R04
         dbg_tms <= sel_reg[BIT_TMS] | pin_in[BIT_TMS];
         dbg_tdi <= sel_reg[BIT_TDI] | pin_in[BIT_TDI];
         swd_active <= swd_reg;
         scan_mode <= boundary_scan_select; // see R06
         test_mode <= test_mode_input; // see R19
      end
   end
   // ****************************************************
   // Reset pin
   // ****************************************************
   logic [$clog2(RST_CYC+1)-1:0] rst_cnt_reg; // Stretch counter.
   logic ext_low; // Low on the pin that this block is not driving itself.
   // While the block pulls the pin low it would otherwise see its own drive and
   // restart the stretch forever, so only an undriven low counts as external.
   assign ext_low = !reset_pin_n_in && !reset_pin_n_oe; // see R10
   // Any external low on the pin or internal request restarts the stretch; backup
   // domain logic is not fed from core_rst_n.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_cnt_reg <= '0;
         core_rst_n <= 1'b0;
         reset_pin_n_out <= 1'b0;
         reset_pin_n_oe <= 1'b0; // see R13
      end else begin
         if (rstc_req || ext_low) begin
            rst_cnt_reg <= ($bits(rst_cnt_reg))'(RST_CYC); // see R12
         end else if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - ($bits(rst_cnt_reg))'(1);
         end
         core_rst_n <= !(rstc_req || ext_low || rst_cnt_reg != '0); // see R10
         reset_pin_n_out <= 1'b0;
         reset_pin_n_oe <= rstc_req || (rst_cnt_reg > 1); // see R11
      end
   end
   // ****************************************************
   // Erase path
   // ****************************************************
   logic erase_lvl; // Erase level counted only in system mode.
   logic erase_fire; // Threshold reached.
   assign erase_lvl = !sel_reg[BIT_ERASE] & pin_in[BIT_ERASE]; // see R18
   spm_erase_filter #(.TICKS(ERASE_TICKS)) u_filt (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(sclk_tick),
      .level(erase_lvl),
      .fire(erase_fire)
   );
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         erase_req <= 1'b0;
      end else begin
         erase_req <= erase_fire; // see R14
      end
   end
   // ****************************************************
   // Checks
   // ****************************************************
   a_port_no_erase: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(sel_reg[BIT_ERASE], 2) && $past(sel_reg[BIT_ERASE]) |-> !erase_req) // see R18
      else $error("Erase from a port-mode pin.");
   a_trace_swd_only: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(swd_reg) && !$past(sel_reg[BIT_TDO]) |-> pin_out[BIT_TDO] == $past(dbg_tdo)) // see R09
      else $error("Trace used under JTAG.");
   a_reset_stretch: assert property (@(posedge mclk) disable iff (!rst_n)
      rstc_req |=> !core_rst_n [*8]) // see R12
      else $error("Reset not stretched.");
   a_sel_write: assert property (@(posedge mclk) disable iff (!rst_n)
      sel_we |=> sel_reg == ($past(sel_wr) & SYSIO_MASK)) // see R01
      else $error("Selection write lost.");
   a_scan_follow: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 scan_mode == $past(boundary_scan_select)) // see R06
      else $error("Scan select not followed.");
endmodule

// ==== dv/spm_probe_model.sv ====
`timescale 1ns/1ns
// ****************************************************
// Board side: debug probe, erase switch, reset button
// ****************************************************
module spm_probe_model (
   input wire logic mclk, // Pacing clock.
   output logic tck,      // Probe clock, still between sequences.
   output logic tms,      // Probe mode and data line.
   output logic erase,    // Erase switch level.
   output logic rst_n     // Reset button, open drain behind a pull-up.
);
   // The erase line is held low from power-up so no erase starts by accident.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      erase = 1'b0;
      rst_n = 1'b1;
   end
   // One probe bit: data changes while the clock is low, taken on its rise.
   task automatic bit_out(input logic b);
      repeat (2) @(posedge mclk);
      #1 tms = b;
      tck = 1'b0;
      repeat (2) @(posedge mclk);
      #1 tck = 1'b1;
   endtask
   // Switch to serial wire: fifty highs, then the code LSB first.
   task automatic swd_switch();
      logic [15:0] code;
      code = 16'hE79E;
      for (int i = 0; i < 50; i++) bit_out(1'b1);
      for (int i = 0; i < 16; i++) bit_out(code[i]);
      @(posedge mclk) #1 tck = 1'b0;
   endtask
   // Hold the erase switch high for n clock cycles, then let go.
   task automatic press_erase(input int n);
      @(posedge mclk) #1 erase = 1'b1;
      repeat (n) @(posedge mclk);
      #1 erase = 1'b0;
   endtask
   // Press the reset button for n cycles.
   task automatic pull_reset(input int n);
      @(posedge mclk) #1 rst_n = 1'b0;
      repeat (n) @(posedge mclk);
      #1 rst_n = 1'b1;
   endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
   import spm_pkg::*;
   localparam int unsigned TK = 4; // Short erase threshold keeps the run brief.
   logic mclk, rst_n, sclk_tick, sel_we, dbg_tdo, dbg_tdo_oe, dbg_swdio_out, dbg_swdio_oe;
   logic trace_data, usb_dm_out, usb_dp_out, usb_oe, boundary_scan_select, test_mode_input;
   logic rstc_req, dbg_tck, dbg_tms, dbg_tdi, swd_active, scan_mode, test_mode, core_rst_n;
   logic reset_pin_n_out, reset_pin_n_oe, erase_req, m_tck, m_tms, m_erase, m_rst_n;
   logic [SYSIO_W-1:0] sel_wr, pad_pu, pad_pd, pad_od, pad_gf, pad_db, pad_ic, rnd;
   logic [SYSIO_W-1:0] port_out, port_oe, sel_q, pin_out, pin_oe, pu_en, pd_en, gf_en, db_en;
   logic [SYSIO_W-1:0] port_in, port_chg, sw;
   wire logic [SYSIO_W-1:0] pin_in;
   wire logic reset_pin_n_in;
   int fail_count, cmp_count, cyc, seed, n_erase, tcnt;
   // Probe lines sit on bits 7 and 6, the erase switch on bit 12.
   assign pin_in = {m_erase, rnd[11:8], m_tck, m_tms, rnd[5:0]};
   // Reset pin wire: either party may pull it low, the pull-up wins otherwise.
   assign reset_pin_n_in = m_rst_n & (reset_pin_n_oe ? reset_pin_n_out : 1'b1);
   spm_sysio_ctrl #(.ERASE_TICKS(TK)) dut_u (.mclk, .rst_n, .sclk_tick, .sel_wr, .sel_we,
      .pad_pu, .pad_pd, .pad_od, .pad_gf, .pad_db, .pad_ic, .pin_in, .port_out, .port_oe,
      .dbg_tdo, .dbg_tdo_oe, .dbg_swdio_out, .dbg_swdio_oe, .trace_data, .usb_dm_out,
      .usb_dp_out, .usb_oe, .boundary_scan_select, .test_mode_input, .reset_pin_n_in,
      .rstc_req, .sel_q, .pin_out, .pin_oe, .pu_en, .pd_en, .gf_en, .db_en, .port_in,
      .port_chg, .dbg_tck, .dbg_tms, .dbg_tdi, .swd_active, .scan_mode, .test_mode,
      .core_rst_n, .reset_pin_n_out, .reset_pin_n_oe, .erase_req);
   spm_probe_model m (.mclk(mclk), .tck(m_tck), .tms(m_tms), .erase(m_erase), .rst_n(m_rst_n));
   // ****************************************************
   // Clock, slow tick, erase counter and watchdog
   // ****************************************************
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;
   // The slow tick comes every eighth cycle; real rate would make the run far too long.
   always @(posedge mclk) begin
      tcnt <= (tcnt + 1) % 8;
      sclk_tick <= (tcnt == 7);
      cyc <= cyc + 1;
      if (erase_req === 1'b1) n_erase <= n_erase + 1;
      if (cyc == 6000) begin
         fail_count++;
         wrap_up();
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Writes a selection word; it shows on sel_q two cycles after the strobe.
   task automatic set_sel(input logic [SYSIO_W-1:0] w);
      @(posedge mclk) #1 sel_wr = w;
      sel_we = 1'b1;
      @(posedge mclk) #1 sel_we = 1'b0;
      repeat (2) @(posedge mclk);
      #1 `CHK("sel_q", w & SYSIO_MASK, sel_q)
   endtask
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      seed = 32'he6c6;
      {fail_count, cmp_count, cyc, n_erase, tcnt} = '0;
      {rst_n, sclk_tick, sel_we, rstc_req, boundary_scan_select, test_mode_input} = '0;
      {sel_wr, pad_pu, pad_pd, pad_od, pad_gf, pad_db, pad_ic, rnd, port_out, port_oe} = '0;
      {dbg_tdo, dbg_tdo_oe, dbg_swdio_out, dbg_swdio_oe, trace_data} = '0;
      {usb_dm_out, usb_dp_out, usb_oe} = '0;
      repeat (5) @(posedge mclk);
      #1 rst_n = 1'b1;
      @(posedge mclk) #1;
      `CHK("sel_q", SYSIO_RST, sel_q)
      `CHK("dbg_tms", 1'b1, dbg_tms)
      `CHK("swd_active", 1'b0, swd_active)
      `CHK("rst_oe", 1'b0, reset_pin_n_oe)
      $display("test defaults done");
      m.swd_switch();
      repeat (4) @(posedge mclk);
      #1 `CHK("swd_active", 1'b1, swd_active)
      // Trace follows the data out line once serial wire is on.
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk) #1 trace_data = $random(seed);
         repeat (2) @(posedge mclk);
         #1 `CHK("trace", trace_data, pin_out[BIT_TDO])
      end
      $display("test debug done");
      // Random selections, pad settings and mode inputs, the all-ones selection first.
      for (int i = 0; i < 20; i++) begin
         {pad_pu, pad_pd, pad_db, rnd, port_out} = {$random(seed), $random(seed)};
         {pad_od, pad_gf, pad_ic, port_oe} = $random(seed);
         {boundary_scan_select, test_mode_input} = $random(seed);
         sw = (i == 0) ? 13'h1_fff : $random(seed);
         set_sel(sw);
         `CHK("pd_en", pad_pd, pd_en)
         `CHK("gf_en", pad_gf, gf_en)
         `CHK("port_in", pin_in & sw & SYSIO_MASK, port_in)
         `CHK("pu_en", pad_pu, pu_en)
         `CHK("db_en", pad_db, db_en)
         `CHK("scan_mode", boundary_scan_select, scan_mode)
         `CHK("test_mode", test_mode_input, test_mode)
      end
      $display("test select done");
      set_sel('0);
      m.press_erase(20);
      repeat (40) @(posedge mclk);
      `CHK("erase_short", 0, n_erase)
      m.press_erase(80);
      repeat (40) @(posedge mclk);
      `CHK("erase_long", 1, n_erase)
      set_sel(13'h1_000);
      m.press_erase(80);
      repeat (40) @(posedge mclk);
      `CHK("erase_port", 1, n_erase)
      $display("test erase done");
      m.pull_reset(3);
      #1 `CHK("core_rst_n", 1'b0, core_rst_n)
      repeat (RST_CYC - 10) @(posedge mclk);
      #1 `CHK("stretch", 1'b0, core_rst_n)
      for (int i = 0; i < 40 && core_rst_n !== 1'b1; i++) @(posedge mclk) #1;
      `CHK("release", 1'b1, core_rst_n)
      @(posedge mclk) #1 rstc_req = 1'b1;
      @(posedge mclk) #1 rstc_req = 0;
      repeat (2) @(posedge mclk);
      #1 `CHK("rst_drive", 2'b10, {reset_pin_n_oe, reset_pin_n_out})
      for (int i = 0; i < 400 && reset_pin_n_oe !== 1'b0; i++) @(posedge mclk) #1;
      `CHK("rst_oe_end", 1'b0, reset_pin_n_oe)
      $display("test reset done");
      wrap_up();
   end
endmodule
